//--- rtl/lbs_bank.sv
// one bank state tracker with its own delay counter
`timescale 1ns/100ps
module lbs_bank (
   input  wire logic              mclk_in,
   input  wire logic              rstn_in,
   input  wire logic              go_in,
   input  wire lbs_pkg::lbs_cmd_type cmd_in,
   input  wire logic              auto_pre_in,
   output lbs_pkg::lbs_bank_type  state_out
);
   import lbs_pkg::*;

   lbs_bank_type     st_reg, st_next;     // bank state
   lbs_bank_type     ret_reg, ret_next;   // state to return to after mrr
   logic [CNT_W-1:0] cnt_reg, cnt_next;   // remaining delay
   logic             ap_reg, ap_next;     // burst ends in precharge

   // load counter, cast to counter width
   function automatic logic [CNT_W-1:0] ld(input int c);
      return CNT_W'(c - 1);
   endfunction

   // next-state logic of the bank
   always_comb begin
      st_next  = st_reg;
      ret_next = ret_reg;
      cnt_next = (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;
      ap_next  = ap_reg;
      if (go_in) begin
         case (cmd_in)
            CMD_RST: begin
               st_next = BS_RESETTING;
               cnt_next = ld(T_INIT_CYC);
            end
            CMD_MRW: begin
               st_next = BS_MRWRITE;
               cnt_next = ld(T_MRW_CYC);
            end
            CMD_PRE, CMD_PREA: begin
               st_next = BS_PRECHARGING;
               cnt_next = ld(T_RP_CYC);
            end
            CMD_ACT: begin
               st_next = BS_ACTIVATING;
               cnt_next = ld(T_RCD_CYC);
            end
            CMD_RD, CMD_WR: begin
               st_next = (cmd_in == CMD_RD) ? BS_READING : BS_WRITING;
               ap_next = auto_pre_in;
               cnt_next = ld(T_BURST_CYC);
            end
            CMD_MRR: begin
               // remember where to land; transitions settle meanwhile
               ret_next = (st_reg == BS_ACTIVATING) ? BS_ACTIVE :
                          (st_reg == BS_PRECHARGING) ? BS_IDLE : st_reg;
               st_next = BS_MRREAD;
               if (cnt_reg < ld(T_MRR_CYC))
                  cnt_next = ld(T_MRR_CYC);
            end
            default: begin
            end
         endcase
      end else if (cnt_reg == '0) begin
         case (st_reg)
            BS_PRECHARGING: st_next = BS_IDLE;
            BS_ACTIVATING:  st_next = BS_ACTIVE;
            BS_MRREAD:      st_next = ret_reg;
            BS_MRWRITE:     st_next = BS_IDLE;
            // initialisation done, bank becomes usable
            BS_RESETTING:   st_next = BS_IDLE;
            BS_READING, BS_WRITING: begin
               if (ap_reg) begin
                  st_next = BS_PRECHARGING;
                  cnt_next = ld(T_RP_CYC);
               end else begin
                  st_next = BS_ACTIVE;
               end
            end
            default: st_next = st_reg;
         endcase
      end
   end

   // state registers
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg  <= BS_POWERON;
         ret_reg <= BS_IDLE;
         cnt_reg <= '0;
         ap_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         ret_reg <= ret_next;
         cnt_reg <= cnt_next;
         ap_reg  <= ap_next;
      end
   end

   assign state_out = st_reg;

   // an mrr may legally cut in, so only quiet precharges are timed
   a_prech_idle: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (go_in && cmd_in inside {CMD_PRE, CMD_PREA}) ##1 !go_in [*3] |->
      st_reg == BS_PRECHARGING ##1 st_reg == BS_IDLE)
      else $error("precharge period wrong");
   a_mrw_idle: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (go_in && cmd_in == CMD_MRW) |=> st_reg == BS_MRWRITE [*5]
      ##1 st_reg == BS_IDLE) else $error("mode write period wrong");
endmodule // lbs_bank

//--- rtl/lbs_ctrl.sv
// controller top: legality checking, command issue and write masking
`timescale 1ns/100ps
module lbs_ctrl (
   input  wire logic                 mclk_in,
   input  wire logic                 rstn_in,
   input  wire logic                 req_valid_in,
   input  wire lbs_pkg::lbs_req_type req_in,
   output logic                      req_ready_out,
   output logic                      req_reject_out,
   input  wire logic                 cke_pin_in,
   input  wire lbs_pkg::lbs_beat_type wbeat_in,
   input  wire logic                 wbeat_valid_in,
   output lbs_pkg::lbs_cmd_type      dram_cmd_out,
   output logic [2:0]                dram_bank_out,
   output logic                      dram_ap_out,
   output logic [lbs_pkg::DQ_W-1:0]  dram_dq_out,
   output logic [lbs_pkg::DM_W-1:0]  dram_dm_out,
   output logic                      dram_dq_oen_out,
   output logic [lbs_pkg::NUM_BANKS-1:0] bank_idle_out
);
   import lbs_pkg::*;

   lbs_bank_type bst [NUM_BANKS];        // bank states
   logic [NUM_BANKS-1:0] sel;            // banks the command touches
   logic  cke_s1_reg, cke_s2_reg, cke_s3_reg; // clock enable synchroniser
   logic [CNT_W-1:0] xp_reg, xp_next;    // exit time counter
   logic [CNT_W-1:0] rrd_reg, rrd_next;  // activate spacing counter
   logic [2:0] lact_reg, lact_next;      // last activated bank
   logic  go;                            // command is issued this cycle
   logic  legal;                         // request is allowed now
   logic  cke_ok;                        // clock enable held two cycles and exit time elapsed
   logic  all_idle, any_mr, any_burst;
   lbs_cmd_type  cmd_reg, cmd_next;      // command pins
   logic [2:0]   bnk_reg, bnk_next;
   logic         ap_reg, ap_next;
   lbs_beat_type beat_reg, beat_next;    // data and mask pins
   logic         oen_reg, oen_next;

   // true when a precharge is valid from this state
   function automatic logic pre_ok(input lbs_bank_type s);
      return s inside {BS_IDLE, BS_ACTIVE, BS_PRECHARGING};
   endfunction

   // two-flop synchroniser, third stage for previous-cycle value
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cke_s1_reg <= 1'b0;
         cke_s2_reg <= 1'b0;
         cke_s3_reg <= 1'b0;
      end else begin
         cke_s1_reg <= cke_pin_in;
         cke_s2_reg <= cke_s1_reg;
         cke_s3_reg <= cke_s2_reg;
      end
   end
   assign cke_ok = cke_s2_reg && cke_s3_reg && (xp_reg == '0);

   // bank trackers
   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      assign sel[b] = (req_in.cmd inside {CMD_PREA, CMD_REF, CMD_MRW,
                       CMD_RST, CMD_MRR}) || (req_in.bank == 3'(b));
      lbs_bank u_bank (
         .mclk_in     (mclk_in),
         .rstn_in     (rstn_in),
         .go_in       (go && sel[b] && req_in.cmd != CMD_REF),
         .cmd_in      (req_in.cmd),
         .auto_pre_in (req_in.auto_pre),
         .state_out   (bst[b])
      );
      assign bank_idle_out[b] = (bst[b] == BS_IDLE);
   end

   // summary flags over all banks
   always_comb begin
      all_idle = 1'b1;
      any_mr = 1'b0;
      any_burst = 1'b0;
      for (int i = 0; i < NUM_BANKS; i++) begin
         if (bst[i] != BS_IDLE) all_idle = 1'b0;
         if (bst[i] inside {BS_MRREAD, BS_MRWRITE}) any_mr = 1'b1;
         if (bst[i] inside {BS_READING, BS_WRITING}) any_burst = 1'b1;
      end
   end

   // legality of the requested command in the current bank state
   always_comb begin
      lbs_bank_type s;
      s = bst[req_in.bank];
      legal = 1'b0;
      if (!any_mr) begin
         case (req_in.cmd)
            CMD_NOP:  legal = 1'b1;
            CMD_ACT:  legal = (s == BS_IDLE) &&
                              (rrd_reg == '0 || req_in.bank == lact_reg);
            CMD_RD:   legal = (s inside {BS_ACTIVE, BS_WRITING, BS_READING})
                              && !(s == BS_WRITING);
            CMD_WR:   legal = (s inside {BS_ACTIVE, BS_WRITING});
            CMD_PRE:  legal = pre_ok(s);
            CMD_PREA: begin
               legal = 1'b1;
               for (int i = 0; i < NUM_BANKS; i++)
                  if (!pre_ok(bst[i])) legal = 1'b0;
            end
            CMD_REF, CMD_MRW: legal = all_idle;
            CMD_RST:  legal = (all_idle || bst[0] == BS_POWERON) &&
                              !any_burst;
            CMD_MRR:  begin
               legal = 1'b1;
               for (int i = 0; i < NUM_BANKS; i++)
                  if (bst[i] inside {BS_READING, BS_WRITING, BS_POWERON})
                     legal = 1'b0;
            end
            default:  legal = 1'b0;
         endcase
      end
   end

   assign go = req_valid_in && cke_ok && legal && req_in.cmd != CMD_NOP;
   assign req_ready_out  = cke_ok && legal;
   assign req_reject_out = req_valid_in && cke_ok && !legal;

   // timing counters and pin registers
   always_comb begin
      xp_next  = cke_ok ? xp_reg : CNT_W'(T_XP_CYC);
      if (cke_s2_reg && cke_s3_reg && xp_reg != '0) xp_next = xp_reg - 1'b1;
      rrd_next = (rrd_reg != '0) ? rrd_reg - 1'b1 : rrd_reg;
      lact_next = lact_reg;
      if (go && req_in.cmd == CMD_ACT) begin
         rrd_next  = CNT_W'(T_RRD_CYC - 1);
         lact_next = req_in.bank;
      end
      cmd_next = go ? req_in.cmd : CMD_NOP;
      bnk_next = go ? req_in.bank : 3'h0;
      ap_next  = go && req_in.auto_pre;
      beat_next = beat_reg;
      oen_next  = 1'b1;
      if (wbeat_valid_in) begin
         beat_next = wbeat_in;
         oen_next  = 1'b0;
      end
   end

   // registers
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         xp_reg   <= '0;
         rrd_reg  <= '0;
         lact_reg <= 3'h0;
         cmd_reg  <= CMD_NOP;
         bnk_reg  <= 3'h0;
         ap_reg   <= 1'b0;
         beat_reg <= '0;
         oen_reg  <= 1'b1;
      end else begin
         xp_reg   <= xp_next;
         rrd_reg  <= rrd_next;
         lact_reg <= lact_next;
         cmd_reg  <= cmd_next;
         bnk_reg  <= bnk_next;
         ap_reg   <= ap_next;
         beat_reg <= beat_next;
         oen_reg  <= oen_next;
      end
   end

   assign dram_cmd_out    = cmd_reg;
   assign dram_bank_out   = bnk_reg;
   assign dram_ap_out     = ap_reg;
   assign dram_dq_out     = beat_reg.data;
   assign dram_dm_out     = beat_reg.mask;
   assign dram_dq_oen_out = oen_reg;

   a_mr_nop: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      any_mr |-> !go) else $error("command during mode register state");
   a_act_space: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (go && req_in.cmd == CMD_ACT) |=> !(go && req_in.cmd == CMD_ACT))
      else $error("activates too close");
   a_cke_gate: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      go |-> cke_s2_reg && $past(cke_s2_reg)) else $error("cke low");
   a_all_idle: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (go && req_in.cmd inside {CMD_REF, CMD_MRW}) |-> all_idle)
      else $error("refresh or mode write not idle");
   a_pin_cmd: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      go |=> dram_cmd_out == $past(req_in.cmd)) else $error("pin cmd");
   a_rd_wr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (go && req_in.cmd == CMD_RD) |-> bst[req_in.bank] != BS_WRITING)
      else $error("read into write burst");
   a_mask_pin: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      wbeat_valid_in |=> dram_dm_out == $past(wbeat_in.mask) && !oen_reg)
      else $error("mask lost");
   a_reset_ok: assert property (@(posedge mclk_in) disable iff (!rstn_in)
      (go && req_in.cmd == CMD_RST) |-> !any_burst)
      else $error("reset during burst");
   c_act: cover property (@(posedge mclk_in) go && req_in.cmd == CMD_ACT);
   c_mrr: cover property (@(posedge mclk_in) go && req_in.cmd == CMD_MRR);
   c_rej: cover property (@(posedge mclk_in) req_reject_out);
endmodule // lbs_ctrl

//--- rtl/lbs_pkg.sv
// package: command codes, bank states and timing counts for the bank sequencer
// How it works
// - commands only with clock enable high twice
// - never issue undefined state-command pairs
// - refresh and mode write need all idle
// - only NOPs during mode register states
// - keep activate-to-activate delay across banks
// - precharge all needs every bank valid
// - no mode write while row activating
// - mode read allowed while precharging
// - reset only when all idle or at power-on, no burst
// - auto precharge then other banks allowed
// - reset is a mode write, starts init
// - mode read in resetting returns to resetting
// - write to reading bank after burst
// - read to writing bank after burst
// - mask bit high inhibits its byte lane of the write beat
package lbs_pkg;
   localparam int NUM_BANKS  = 8;    // banks tracked
   localparam int CNT_W      = 8;    // width of delay counters
   localparam int T_RP_CYC   = 3;    // precharge period, cycles
   localparam int T_RCD_CYC  = 3;    // activate-to-column, cycles
   localparam int T_RRD_CYC  = 2;    // activate-to-activate, cycles
   localparam int T_MRR_CYC  = 4;    // mode read period, cycles
   localparam int T_MRW_CYC  = 5;    // mode write period, cycles
   localparam int T_BURST_CYC = 4;   // burst length 8 at two beats/clock
   localparam int T_XP_CYC   = 2;    // exit time from power down
   localparam int T_INIT_CYC = 8;    // self-initialisation after reset
   localparam int DQ_W       = 32;   // data width
   localparam int DM_W       = 4;    // mask lanes

   // command codes presented by the user side
   typedef enum logic [3:0] {
      CMD_NOP  = 4'h0,
      CMD_ACT  = 4'h1,
      CMD_RD   = 4'h2,
      CMD_WR   = 4'h3,
      CMD_PRE  = 4'h4,
      CMD_PREA = 4'h5,
      CMD_REF  = 4'h6,
      CMD_MRR  = 4'h7,
      CMD_MRW  = 4'h8,
      CMD_RST  = 4'h9
   } lbs_cmd_type;

   // per-bank state
   typedef enum logic [3:0] {
      BS_POWERON  = 4'h0,
      BS_RESETTING = 4'h1,
      BS_IDLE     = 4'h2,
      BS_ACTIVATING = 4'h3,
      BS_ACTIVE   = 4'h4,
      BS_READING  = 4'h5,
      BS_WRITING  = 4'h6,
      BS_PRECHARGING = 4'h7,
      BS_MRREAD   = 4'h8,
      BS_MRWRITE  = 4'h9
   } lbs_bank_type;

   // request from the user side
   typedef struct packed {
      lbs_cmd_type cmd;
      logic [2:0]  bank;
      logic        auto_pre;
   } lbs_req_type;

   // one write beat with its mask
   typedef struct packed {
      logic [DQ_W-1:0] data;
      logic [DM_W-1:0] mask;
   } lbs_beat_type;
endpackage

//--- tb/lbs_dev_model.sv
// behavioural device: bank states, command legality, masked write store
`timescale 1ns/100ps
module lbs_dev_model (
   input  wire logic                    mclk_in,
   input  wire logic                    cke_in,
   input  wire lbs_pkg::lbs_cmd_type    cmd_in,
   input  wire logic [2:0]              bank_in,
   input  wire logic                    ap_in,
   input  wire logic [lbs_pkg::DQ_W-1:0] dq_in,
   input  wire logic [lbs_pkg::DM_W-1:0] dm_in,
   input  wire logic                    oen_in,
   output int                           bad_out,
   output logic [lbs_pkg::DQ_W-1:0]     word_out
);
   import lbs_pkg::*;
   lbs_bank_type st [NUM_BANKS];  // state of each bank
   int           cnt [NUM_BANKS]; // cycles left in a timed state
   int           mr_cnt = 0;      // nop-only window left
   int           rrd_cnt = 0;     // activate spacing left
   logic         cke_q = 1'b0;    // clock enable one cycle back
   logic         idle, pon, rd;   // all idle, all powered on, read
   initial begin
      bad_out = 0;
      word_out = '0;
      foreach (st[i]) st[i] = BS_POWERON;
      foreach (cnt[i]) cnt[i] = 0;
   end
   // timed states settle first, then the new command is judged
   always @(posedge mclk_in) begin
      if (mr_cnt > 0) mr_cnt--;
      if (rrd_cnt > 0) rrd_cnt--;
      foreach (st[i]) begin
         if (cnt[i] > 0) cnt[i]--;
         if (cnt[i] == 0 && st[i] == BS_ACTIVATING) st[i] = BS_ACTIVE;
         if (cnt[i] == 0 && st[i] inside {BS_PRECHARGING, BS_RESETTING})
            st[i] = BS_IDLE;
      end
      idle = 1'b1;
      pon = 1'b1;
      foreach (st[i]) begin
         idle &= (st[i] == BS_IDLE);
         pon &= (st[i] == BS_POWERON);
      end
      if (cke_q && cke_in && cmd_in != CMD_NOP) begin
         if (mr_cnt > 0) bad_out++;
         case (cmd_in)
            CMD_ACT: begin
               if (st[bank_in] != BS_IDLE || rrd_cnt > 0) bad_out++;
               st[bank_in] = BS_ACTIVATING;
               cnt[bank_in] = T_RCD_CYC;
               rrd_cnt = T_RRD_CYC;
            end
            CMD_RD, CMD_WR: begin
               rd = (cmd_in == CMD_RD);
               if (!(st[bank_in] inside {BS_ACTIVE, BS_READING, BS_WRITING}))
                  bad_out++;
               if (cnt[bank_in] > 0 && (st[bank_in] == BS_READING) != rd)
                  bad_out++;
               st[bank_in] = ap_in ? BS_PRECHARGING :
                             rd ? BS_READING : BS_WRITING;
               cnt[bank_in] = ap_in ? T_BURST_CYC + T_RP_CYC : T_BURST_CYC;
            end
            CMD_PRE, CMD_PREA: begin
               foreach (st[i])
                  if (cmd_in == CMD_PREA || i == bank_in) begin
                     if (st[i] inside {BS_POWERON, BS_RESETTING}) bad_out++;
                     st[i] = BS_PRECHARGING;
                     cnt[i] = T_RP_CYC;
                  end
            end
            CMD_REF: if (!idle) bad_out++;
            CMD_MRW: begin
               if (!idle) bad_out++;
               mr_cnt = T_MRW_CYC;
            end
            CMD_MRR: mr_cnt = T_MRR_CYC;
            CMD_RST: begin
               if (!(idle || pon)) bad_out++;
               // banks self-initialise for a fixed count, then idle
               foreach (st[i]) st[i] = BS_RESETTING;
               foreach (cnt[i]) cnt[i] = T_INIT_CYC;
            end
            default: bad_out++;
         endcase
      end
      cke_q = cke_in;
      // only unmasked byte lanes reach the store
      if (!oen_in)
         for (int k = 0; k < DM_W; k++)
            if (!dm_in[k]) word_out[8*k +: 8] = dq_in[8*k +: 8];
   end
endmodule // lbs_dev_model

//--- tb/tb.sv
// self-checking bench: reset, legality table, clock enable, masking
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
   import lbs_pkg::*;
   // one request with its expected acceptance and idle map
   typedef struct {
      lbs_cmd_type c;
      logic [2:0]  b;
      logic        ap;
      logic        ok;
      int          gap;
      logic [7:0]  idl;
   } lbs_row_type;
   logic            mclk, rstn, req_valid, cke, wvalid, rdy, rej, dap, oen;
   lbs_req_type     rq;
   lbs_beat_type    wbeat;
   lbs_cmd_type     dcmd;
   logic [2:0]      dbank;
   logic [DQ_W-1:0] dq, word;
   logic [DM_W-1:0] dm;
   logic [7:0]      idl;
   int              fails, n_tests, bad, cyc;
   lbs_row_type rows [22] = '{
      '{CMD_ACT, 1, 0, 1, 0, 0}, '{CMD_ACT, 2, 0, 0, 0, 0},
      '{CMD_MRW, 0, 0, 0, 0, 0}, '{CMD_MRR, 0, 0, 1, 0, 0},
      '{CMD_RD, 1, 0, 0, 6, 'hfd}, '{CMD_WR, 1, 0, 1, 0, 0},
      '{CMD_RD, 1, 0, 0, 6, 'hfd}, '{CMD_RD, 1, 0, 1, 0, 0},
      '{CMD_WR, 1, 0, 0, 6, 'hfd}, '{CMD_WR, 1, 0, 1, 6, 'hfd},
      '{CMD_REF, 0, 0, 0, 0, 0}, '{CMD_RST, 0, 0, 0, 0, 0},
      '{CMD_PRE, 1, 0, 1, 0, 0}, '{CMD_MRR, 0, 0, 1, 6, 'hff},
      '{CMD_ACT, 3, 0, 1, 4, 'hf7}, '{CMD_RD, 3, 1, 1, 12, 'hff},
      '{CMD_MRW, 0, 0, 1, 0, 0}, '{CMD_ACT, 0, 0, 0, 8, 'hff},
      '{CMD_REF, 0, 0, 1, 2, 'hff}, '{CMD_PREA, 0, 0, 1, 4, 'hff},
      '{CMD_ACT, 4, 0, 1, 4, 'hef}, '{CMD_WR, 4, 0, 1, 0, 0}};
   lbs_ctrl DUT (
      .mclk_in(mclk), .rstn_in(rstn), .req_valid_in(req_valid),
      .req_in(rq), .req_ready_out(rdy), .req_reject_out(rej),
      .cke_pin_in(cke), .wbeat_in(wbeat), .wbeat_valid_in(wvalid),
      .dram_cmd_out(dcmd), .dram_bank_out(dbank), .dram_ap_out(dap),
      .dram_dq_out(dq), .dram_dm_out(dm), .dram_dq_oen_out(oen),
      .bank_idle_out(idl));
   lbs_dev_model dev (
      .mclk_in(mclk), .cke_in(cke), .cmd_in(dcmd), .bank_in(dbank),
      .ap_in(dap), .dq_in(dq), .dm_in(dm), .oen_in(oen),
      .bad_out(bad), .word_out(word));
   // clock source
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // print counts and verdict, then stop
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // present one request at a falling edge, judge it, see the pins
   task automatic req(lbs_cmd_type c, logic [2:0] b, logic ap, logic ok);
      req_valid = 1'b1;
      rq = '{c, b, ap};
      #1;
      `CHK(rdy, ok)
      `CHK(rej, !ok)
      @(negedge mclk);
      `CHK(dcmd, ok ? c : CMD_NOP)
   endtask
   // hang guard
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         wrap_up;
      end
   end
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      cke = 1'b1;
      wvalid = 1'b0;
      rq = '{CMD_NOP, 3'h0, 1'b0};
      wbeat = '0;
      repeat (3) @(negedge mclk);
      `CHK(idl, 8'h00)
      `CHK(dcmd, CMD_NOP)
      `CHK(oen, 1'b1)
      rstn = 1'b1;
      repeat (10) @(negedge mclk);
      req(CMD_ACT, 0, 0, 0);
      req(CMD_RST, 0, 0, 1);
      req_valid = 1'b0;
      repeat (2) @(negedge mclk);
      req(CMD_MRR, 0, 0, 1);
      req(CMD_ACT, 0, 0, 0);
      req_valid = 1'b0;
      for (int k = 0; k < 500 && idl !== 8'hff; k++) @(negedge mclk);
      `CHK(idl, 8'hff)
      cke = 1'b0;
      repeat (3) @(negedge mclk);
      // legal activate, held off only by clock enable: no reject pulse
      req_valid = 1'b1;
      rq = '{CMD_ACT, 3'h0, 1'b0};
      #1;
      `CHK(rdy, 1'b0)
      `CHK(rej, 1'b0)
      @(negedge mclk);
      `CHK(dcmd, CMD_NOP)
      req_valid = 1'b0;
      cke = 1'b1;
      repeat (10) @(negedge mclk);
      foreach (rows[i]) begin
         req(rows[i].c, rows[i].b, rows[i].ap, rows[i].ok);
         if (rows[i].gap > 0) begin
            req_valid = 1'b0;
            repeat (rows[i].gap) @(negedge mclk);
            `CHK(idl, rows[i].idl)
         end
      end
      req_valid = 1'b0;
      wbeat = '{32'haaaaaaaa, 4'h0};
      wvalid = 1'b1;
      @(negedge mclk);
      wbeat = '{32'h55555555, 4'h5};
      @(negedge mclk);
      wvalid = 1'b0;
      repeat (8) @(negedge mclk);
      `CHK(word, 32'h55aa55aa)
      `CHK(bad, 0)
      wrap_up;
   end
endmodule // tb
